// ---- inc/cad_pkg.sv ----
// Constants shared by the condition and addressing mode decoder.
package cad_pkg;
   // Condition suffix codes held in the top nibble of the word.
   localparam logic [3:0] COND_EQ = 4'h0;
   localparam logic [3:0] COND_NE = 4'h1;
   localparam logic [3:0] COND_CS = 4'h2;
   localparam logic [3:0] COND_CC = 4'h3;
   localparam logic [3:0] COND_MI = 4'h4;
   localparam logic [3:0] COND_PL = 4'h5;
   localparam logic [3:0] COND_VS = 4'h6;
   localparam logic [3:0] COND_VC = 4'h7;
   localparam logic [3:0] COND_UGT    = 4'h8;
   localparam logic [3:0] COND_ULE    = 4'h9;
   localparam logic [3:0] COND_SGE    = 4'hA;
   localparam logic [3:0] COND_SLT    = 4'hB;
   localparam logic [3:0] COND_SGT    = 4'hC;
   localparam logic [3:0] COND_SLE    = 4'hD;
   localparam logic [3:0] COND_ALWAYS = 4'hE;
   // Instruction classes given by the fetch stage.
   localparam logic [2:0] CLS_DATA   = 3'h0;
   localparam logic [2:0] CLS_PRIV   = 3'h1;
   localparam logic [2:0] CLS_MLOAD  = 3'h2;
   localparam logic [2:0] CLS_MSTORE = 3'h3;
   localparam logic [2:0] CLS_COPROC = 3'h4;
   localparam logic [2:0] CLS_PSRW   = 3'h5;
   // Field positions inside the instruction word.
   localparam int COND_HI_BIT = 31;
   localparam int COND_LO_BIT = 28;
   localparam int IMM_BIT     = 25;
   localparam int PRE_BIT     = 24;
   localparam int UP_BIT      = 23;
   localparam int WB_BIT      = 21;
   localparam int LOAD_BIT    = 20;
   localparam int STK_HI      = 24;
   localparam int STK_LO      = 23;
   localparam int MASK_HI     = 19;
   localparam int MASK_LO     = 16;
   localparam int OFF12_HI    = 11;
   localparam int ROT_HI      = 11;
   localparam int ROT_LO      = 8;
   localparam int SAMT_HI     = 11;
   localparam int SAMT_LO     = 7;
   localparam int STYP_HI     = 6;
   localparam int STYP_LO     = 5;
   localparam int SREG_BIT    = 4;
   localparam int OFF8_HI     = 7;
   // Status register field mask bits.
   localparam int MASK_FLAGS  = 0;
   localparam int MASK_STATUS = 1;
   localparam int MASK_EXT    = 2;
   localparam int MASK_CTRL   = 3;
   // Shift kinds.
   localparam logic [1:0] SH_LSL = 2'h0;
   localparam logic [1:0] SH_LSR = 2'h1;
   localparam logic [1:0] SH_ASR = 2'h2;
   localparam logic [1:0] SH_ROR = 2'h3;
   localparam logic [7:0] SH_FULL = 8'h20;
   // Stack types and address sequencing.
   localparam logic [1:0] STK_FULL_DESC  = 2'h0;
   localparam logic [1:0] STK_EMPTY_DESC = 2'h1;
   localparam logic [1:0] STK_FULL_ASC   = 2'h2;
   localparam logic [1:0] STK_EMPTY_ASC  = 2'h3;
   localparam logic [1:0] SEQ_INC_AFTER  = 2'h1;
   localparam logic [1:0] SEQ_INC_BEFORE = 2'h3;
   localparam logic [1:0] SEQ_DEC_AFTER  = 2'h0;
   localparam logic [1:0] SEQ_DEC_BEFORE = 2'h2;
   // Register map.
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_EXEC   = 8'h08;
   localparam logic [7:0] REG_SKIP   = 8'h0C;
   localparam int         CTRL_EN    = 0;
   localparam logic       CTRL_RST   = 1'b1;
endpackage

// ---- logic/cad_shifter.sv ----
// Barrel shifter with carry out for operands and scaled offsets.
`timescale 1ns/1ns
`default_nettype none
module cad_shifter (
   input  wire logic [31:0] val_i,    // Value to shift.
   input  wire logic [7:0]  amt_i,    // Shift amount, 0 to 255.
   input  wire logic [1:0]  kind_i,   // Shift kind.
   input  wire logic        rext_i,   // Rotate extend through carry.
   input  wire logic        carry_i,  // Carry flag in.
   output logic      [31:0] res_o,    // Shifted value.
   output logic             carry_o   // Shifter carry out.
);
   logic [32:0] t;
   logic [63:0] rot;

   always_comb begin
      t     = 33'h0;
      rot   = {val_i, val_i} >> amt_i[4:0];
      res_o = val_i;
      carry_o = carry_i;
      if (rext_i) begin
         res_o   = {carry_i, val_i[31:1]};
         carry_o = val_i[0];
      end else if (amt_i != 8'h00) begin
         case (kind_i)
            cad_pkg::SH_LSL: begin
               t       = {1'b0, val_i} << amt_i;
               res_o   = t[31:0];
               carry_o = t[32];
            end
            cad_pkg::SH_LSR: begin
               t       = {val_i, 1'b0} >> amt_i;
               res_o   = t[32:1];
               carry_o = t[0];
            end
            cad_pkg::SH_ASR: begin
               t       = 33'($signed({val_i, 1'b0}) >>> amt_i);
               res_o   = t[32:1];
               carry_o = t[0];
            end
            default: begin
               res_o   = rot[31:0];
               carry_o = rot[31];
            end
         endcase
      end
   end
endmodule // cad_shifter
`default_nettype wire

// ---- logic/cad_decoder.sv ----
// Condition evaluation and addressing mode decode with a register port.
//
// Implementation choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Simple suffixes test one flag set or clear.
// - Higher needs carry set, zero clear; lower-or-same is its complement.
// - Greater-or-equal when N equals V; less-than when they differ.
// - Greater-than: Z clear, N=V; less-or-equal the inverse; always passes.
// - Mask bits 0 to 3 enable flags, status, extension, control fields.
// - Privileged word/byte: offset or post-indexed, no pre-indexed writeback.
// - Scaled index shifts by 5-bit amount, or rotates one through carry.
// - Load multiple maps each stack type to its address sequencing.
// - Store multiple uses the same stack to sequencing map.
// - Coprocessor pre-indexed address is base plus or minus 8-bit offset times four.
// - Second operand is rotated immediate, register, or shifted register.
module cad_decoder (
   input  wire logic        clk_i,         // Core clock.
   input  wire logic        rst_i,         // Synchronous reset.
   input  wire logic        wb_cyc_i,      // Bus cycle.
   input  wire logic        wb_stb_i,      // Bus strobe.
   input  wire logic        wb_we_i,       // Bus write.
   input  wire logic [7:0]  wb_adr_i,      // Bus byte address.
   input  wire logic [3:0]  wb_sel_i,      // Bus byte enables.
   input  wire logic [31:0] wb_dat_i,      // Bus write data.
   output logic      [31:0] wb_dat_o,      // Bus read data.
   output logic             wb_ack_o,      // Bus acknowledge.
   input  wire logic        instr_valid_i, // Instruction present.
   input  wire logic [31:0] instr_i,       // Instruction word.
   input  wire logic [2:0]  class_i,       // Instruction class.
   input  wire logic        flag_n_i,      // Negative flag.
   input  wire logic        flag_z_i,      // Zero flag.
   input  wire logic        flag_c_i,      // Carry flag.
   input  wire logic        flag_v_i,      // Overflow flag.
   input  wire logic [31:0] base_i,        // Base register value.
   input  wire logic [31:0] index_i,       // Index or operand register.
   input  wire logic [31:0] shift_reg_i,   // Shift amount register.
   output logic             valid_o,       // Decode result present.
   output logic             cond_pass_o,   // Condition passed.
   output logic      [31:0] operand2_o,    // Flexible second operand.
   output logic             shift_carry_o, // Shifter carry out.
   output logic      [31:0] address_o,     // Access address.
   output logic      [31:0] base_update_o, // New base value.
   output logic             base_write_o,  // Write new base.
   output logic             mem_access_o,  // Memory access enable.
   output logic             reg_write_o,   // Register writeback.
   output logic      [1:0]  multi_seq_o,   // Multiple sequencing.
   output logic      [3:0]  psr_field_we_o // Status field enables.
);
   logic        dec_en;
   logic [31:0] exec_cnt;
   logic [31:0] skip_cnt;
   logic [3:0]  cond_w;
   logic        next_pass;
   logic [31:0] sh_val;
   logic [7:0]  sh_amt;
   logic [1:0]  sh_kind;
   logic        sh_rext;
   logic [31:0] sh_res;
   logic        sh_c;
   logic [4:0]  imm5;
   logic [31:0] off;
   logic [31:0] calc;
   logic [31:0] next_addr;
   logic [31:0] next_upd;
   logic        next_bw;
   logic        next_mem;
   logic        next_rw;
   logic [1:0]  next_seq;
   logic [3:0]  next_psr;
   logic        bus_req;

   function automatic logic cad_cond_eval(input logic [3:0] c,
         input logic n, input logic z, input logic cy, input logic v);
      case (c)
         cad_pkg::COND_EQ: return z;
         cad_pkg::COND_NE: return !z;
         cad_pkg::COND_CS: return cy;
         cad_pkg::COND_CC: return !cy;
         cad_pkg::COND_MI: return n;
         cad_pkg::COND_PL: return !n;
         cad_pkg::COND_VS: return v;
         cad_pkg::COND_VC: return !v;
         cad_pkg::COND_UGT: return cy && !z;
         cad_pkg::COND_ULE: return !cy || z;
         cad_pkg::COND_SGE: return n == v;
         cad_pkg::COND_SLT: return n != v;
         cad_pkg::COND_SGT: return !z && (n == v);
         cad_pkg::COND_SLE: return z || (n != v);
         cad_pkg::COND_ALWAYS: return 1'b1;
         default:          return 1'b0;
      endcase
   endfunction

   function automatic logic [31:0] cad_offset(input logic [31:0] b,
         input logic [31:0] o, input logic up);
      return up ? b + o : b - o;
   endfunction

   function automatic logic [1:0] cad_stack_seq(input logic [1:0] s);
      case (s)
         cad_pkg::STK_FULL_DESC:  return cad_pkg::SEQ_INC_AFTER;
         cad_pkg::STK_EMPTY_DESC: return cad_pkg::SEQ_INC_BEFORE;
         cad_pkg::STK_FULL_ASC:   return cad_pkg::SEQ_DEC_AFTER;
         default:         return cad_pkg::SEQ_DEC_BEFORE;
      endcase
   endfunction

   assign cond_w  = instr_i[cad_pkg::COND_HI_BIT:cad_pkg::COND_LO_BIT];
   assign imm5    = instr_i[cad_pkg::SAMT_HI:cad_pkg::SAMT_LO];
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

   // Software can switch decoding off; every instruction then fails.
   always_comb begin
      next_pass = dec_en && cad_cond_eval(cond_w, flag_n_i, flag_z_i,
                                          flag_c_i, flag_v_i);
   end

   // Shifter source: rotated immediate, register shift or immediate shift.
   always_comb begin
      sh_kind = instr_i[cad_pkg::STYP_HI:cad_pkg::STYP_LO];
      sh_val  = index_i;
      sh_rext = 1'b0;
      sh_amt  = {3'h0, imm5};
      if (class_i == cad_pkg::CLS_DATA && instr_i[cad_pkg::IMM_BIT]) begin
         sh_val  = {24'h0, instr_i[cad_pkg::OFF8_HI:0]};
         sh_kind = cad_pkg::SH_ROR;
         sh_amt  = {3'h0, instr_i[cad_pkg::ROT_HI:cad_pkg::ROT_LO],
                    1'b0};
      end else if (class_i == cad_pkg::CLS_DATA &&
                   instr_i[cad_pkg::SREG_BIT]) begin
         sh_amt = shift_reg_i[7:0];
      end else if (imm5 == 5'h00) begin
         // A zero immediate means a full LSR or ASR shift, the carry rotate for ROR, or no shift for LSL.
         if (sh_kind == cad_pkg::SH_LSR || sh_kind == cad_pkg::SH_ASR) begin
            sh_amt = cad_pkg::SH_FULL;
         end
         sh_rext = (sh_kind == cad_pkg::SH_ROR);
      end
   end

   cad_shifter u_shifter (
      .val_i   (sh_val),
      .amt_i   (sh_amt),
      .kind_i  (sh_kind),
      .rext_i  (sh_rext),
      .carry_i (flag_c_i),
      .res_o   (sh_res),
      .carry_o (sh_c)
   );

   // Address forming and side effects per class.
   always_comb begin
      off       = 32'h0;
      calc      = base_i;
      next_addr = base_i;
      next_upd  = base_i;
      next_bw   = 1'b0;
      next_mem  = 1'b0;
      next_rw   = 1'b0;
      next_seq  = cad_pkg::SEQ_INC_AFTER;
      next_psr  = 4'h0;
      case (class_i)
         cad_pkg::CLS_DATA: begin
            next_rw = 1'b1;
         end
         cad_pkg::CLS_PRIV: begin
            off = instr_i[cad_pkg::IMM_BIT] ? sh_res :
                  {20'h0, instr_i[cad_pkg::OFF12_HI:0]};
            calc     = cad_offset(base_i, off, instr_i[cad_pkg::UP_BIT]);
            next_mem = 1'b1;
            next_rw  = instr_i[cad_pkg::LOAD_BIT];
            if (instr_i[cad_pkg::PRE_BIT]) begin
               next_addr = calc;
            end else begin
               next_upd = calc;
               next_bw  = 1'b1;
            end
         end
         cad_pkg::CLS_MLOAD: begin
            next_mem = 1'b1;
            next_rw  = 1'b1;
            next_bw  = instr_i[cad_pkg::WB_BIT];
            next_seq = cad_stack_seq(
                          instr_i[cad_pkg::STK_HI:cad_pkg::STK_LO]);
         end
         cad_pkg::CLS_MSTORE: begin
            next_mem = 1'b1;
            next_bw  = instr_i[cad_pkg::WB_BIT];
            next_seq = cad_stack_seq(
                          instr_i[cad_pkg::STK_HI:cad_pkg::STK_LO]);
         end
         cad_pkg::CLS_COPROC: begin
            off  = {22'h0, instr_i[cad_pkg::OFF8_HI:0], 2'b00};
            calc = cad_offset(base_i, off, instr_i[cad_pkg::UP_BIT]);
            next_mem = 1'b1;
            next_upd = calc;
            if (instr_i[cad_pkg::PRE_BIT]) begin
               next_addr = calc;
               next_bw   = instr_i[cad_pkg::WB_BIT];
            end else begin
               next_bw = 1'b1;
            end
         end
         cad_pkg::CLS_PSRW: begin
            next_psr = instr_i[cad_pkg::MASK_HI:cad_pkg::MASK_LO];
         end
         default: begin
            next_rw = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         valid_o <= 1'b0;
      end else begin
         valid_o <= instr_valid_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cond_pass_o    <= 1'b0;
         operand2_o     <= 32'h0;
         shift_carry_o  <= 1'b0;
         address_o      <= 32'h0;
         base_update_o  <= 32'h0;
         multi_seq_o    <= cad_pkg::SEQ_INC_AFTER;
      end else if (instr_valid_i) begin
         cond_pass_o    <= next_pass;
         operand2_o     <= sh_res;
         shift_carry_o  <= sh_c;
         address_o      <= next_addr;
         base_update_o  <= next_upd;
         multi_seq_o    <= next_seq;
      end
   end

   // Side effects only leave the block when the condition passed.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         base_write_o   <= 1'b0;
         mem_access_o   <= 1'b0;
         reg_write_o    <= 1'b0;
         psr_field_we_o <= 4'h0;
      end else begin
         base_write_o   <= instr_valid_i && next_pass && next_bw;
         mem_access_o   <= instr_valid_i && next_pass && next_mem;
         reg_write_o    <= instr_valid_i && next_pass && next_rw;
         psr_field_we_o <= (instr_valid_i && next_pass) ? next_psr
                                                        : 4'h0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         exec_cnt <= 32'h0;
         skip_cnt <= 32'h0;
      end else if (instr_valid_i) begin
         if (next_pass) begin
            exec_cnt <= exec_cnt + 32'h1;
         end else begin
            skip_cnt <= skip_cnt + 32'h1;
         end
      end
   end

   // Wishbone slave: ack one cycle late; writes land on the ack edge.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= 32'h0;
         if (bus_req && !wb_we_i) begin
            case (wb_adr_i)
               cad_pkg::REG_CTRL:   wb_dat_o <= {31'h0, dec_en};
               cad_pkg::REG_STATUS: wb_dat_o <= {24'h0, flag_n_i, flag_z_i,
                                                 flag_c_i, flag_v_i, 3'h0,
                                                 cond_pass_o};
               cad_pkg::REG_EXEC:   wb_dat_o <= exec_cnt;
               cad_pkg::REG_SKIP:   wb_dat_o <= skip_cnt;
               default:             wb_dat_o <= 32'h0;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dec_en <= cad_pkg::CTRL_RST;
      end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i &&
                   wb_sel_i[0] && wb_adr_i == cad_pkg::REG_CTRL) begin
         dec_en <= wb_dat_i[cad_pkg::CTRL_EN];
      end
   end

   a_cond_zero: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (instr_valid_i && dec_en && cond_w == cad_pkg::COND_EQ)
      |=> (cond_pass_o == $past(flag_z_i)))
      else $error("Equal condition does not follow the zero flag.");

   a_cond_higher: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (instr_valid_i && dec_en && cond_w == cad_pkg::COND_UGT)
      |=> (cond_pass_o == ($past(flag_c_i) && !$past(flag_z_i))))
      else $error("Unsigned higher condition is wrong.");

   a_cond_signed: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (instr_valid_i && dec_en && cond_w == cad_pkg::COND_SLT)
      |=> (cond_pass_o == ($past(flag_n_i) != $past(flag_v_i))))
      else $error("Less than condition is wrong.");

   a_cond_always: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (instr_valid_i && dec_en && cond_w == cad_pkg::COND_ALWAYS)
      |=> cond_pass_o && valid_o)
      else $error("Always condition failed.");

   a_field_mask: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (instr_valid_i && next_pass && class_i == cad_pkg::CLS_PSRW)
      |=> (psr_field_we_o ==
           $past(instr_i[cad_pkg::MASK_HI:cad_pkg::MASK_LO])))
      else $error("Status field enables do not match the mask.");

   a_priv_nowb: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (instr_valid_i && class_i == cad_pkg::CLS_PRIV &&
       instr_i[cad_pkg::PRE_BIT])
      |=> !base_write_o)
      else $error("Privileged offset form wrote back the base.");

   a_load_stack: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (instr_valid_i && class_i == cad_pkg::CLS_MLOAD &&
       instr_i[cad_pkg::STK_HI:cad_pkg::STK_LO] == cad_pkg::STK_EMPTY_DESC)
      |=> (multi_seq_o == cad_pkg::SEQ_INC_BEFORE))
      else $error("Empty descending load is not increment before.");

   a_store_stack: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (instr_valid_i && class_i == cad_pkg::CLS_MSTORE &&
       instr_i[cad_pkg::STK_HI:cad_pkg::STK_LO] == cad_pkg::STK_FULL_ASC)
      |=> (multi_seq_o == cad_pkg::SEQ_DEC_AFTER))
      else $error("Full ascending store is not decrement after.");

   a_coproc_addr: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (instr_valid_i && class_i == cad_pkg::CLS_COPROC &&
       instr_i[cad_pkg::PRE_BIT] && instr_i[cad_pkg::UP_BIT])
      |=> (address_o == $past(base_i) +
           {22'h0, $past(instr_i[cad_pkg::OFF8_HI:0]), 2'b00}))
      else $error("Coprocessor address is not base plus offset times 4.");

   a_fail_quiet: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (valid_o && !cond_pass_o) |-> (!reg_write_o && !mem_access_o &&
       !base_write_o && psr_field_we_o == 4'h0))
      else $error("Failed instruction still has side effects.");

   a_bus_ack: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("Acknowledge held longer than one cycle.");
endmodule // cad_decoder
`default_nettype wire

// ---- verif/tb.sv ----
// Self-checking testbench for the condition and addressing decoder.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb;
   logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, instr_i = 32'h0, operand2_o;
   logic [31:0] base_i = 32'h1000, index_i = 32'h80, shift_reg_i = 32'h4;
   logic [31:0] address_o, base_update_o, q;
   logic [2:0]  class_i = 3'h0;
   logic [1:0]  multi_seq_o;
   logic [3:0]  psr_field_we_o;
   logic instr_valid_i = 0, flag_n_i = 0, flag_z_i = 0, flag_c_i = 0;
   logic flag_v_i = 0, wb_ack_o, valid_o, cond_pass_o, shift_carry_o;
   logic base_write_o, mem_access_o, reg_write_o;
   int error_cnt = 0, n_checks = 0, cycles = 0;
   cad_decoder DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
      .class_i(class_i), .flag_n_i(flag_n_i), .flag_z_i(flag_z_i),
      .flag_c_i(flag_c_i), .flag_v_i(flag_v_i), .base_i(base_i),
      .index_i(index_i), .shift_reg_i(shift_reg_i), .valid_o(valid_o),
      .cond_pass_o(cond_pass_o), .operand2_o(operand2_o),
      .shift_carry_o(shift_carry_o), .address_o(address_o),
      .base_update_o(base_update_o), .base_write_o(base_write_o),
      .mem_access_o(mem_access_o), .reg_write_o(reg_write_o),
      .multi_seq_o(multi_seq_o), .psr_field_we_o(psr_field_we_o));
   always #25 clk_i = ~clk_i;
   task automatic conclude;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         error_cnt++;
         conclude();
      end
   end
   // Expected pass for each condition code, flags given as n z c v.
   function automatic logic cx(input logic [3:0] c, input logic [3:0] f);
      logic n, z, cy, v;
      logic [15:0] t;
      {n, z, cy, v} = f;
      t = {1'b0, 1'b1, z | (n ^ v), !z & (n == v), n ^ v, n == v, !cy | z,
           cy & !z, !v, v, !n, n, !cy, cy, !z, z};
      return t[c];
   endfunction
   task automatic dec(input logic [2:0] c, input logic [31:0] w,
                      input logic [3:0] f);
      @(posedge clk_i);
      instr_i <= w;
      class_i <= c;
      {flag_n_i, flag_z_i, flag_c_i, flag_v_i} <= f;
      instr_valid_i <= 1'b1;
      @(posedge clk_i);
      instr_valid_i <= 1'b0;
      #1;
      `CHK("valid", 1'b1, valid_o)
   endtask
   task automatic wb(input logic we, input logic [7:0] a,
                     input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic t_cond;
      logic p;
      for (int c = 0; c < 16; c++) begin
         for (int f = 0; f < 16; f++) begin
            p = cx(c[3:0], f[3:0]);
            dec(cad_pkg::CLS_DATA, {c[3:0], 28'h0}, f[3:0]);
            `CHK("cond", p, cond_pass_o)
            `CHK("regwr", p, reg_write_o)
         end
      end
   endtask
   task automatic t_op2;
      dec(cad_pkg::CLS_DATA, 32'hE20004FF, 4'h0);
      `CHK("imm", 32'hFF000000, operand2_o)
      `CHK("immc", 1'b1, shift_carry_o)
      dec(cad_pkg::CLS_DATA, 32'hE0000030, 4'h0);
      `CHK("regsh", 32'h8, operand2_o)
      dec(cad_pkg::CLS_DATA, 32'hE0000C00, 4'h0);
      `CHK("lsl24", 32'h80000000, operand2_o)
      dec(cad_pkg::CLS_DATA, 32'hE0000060, 4'h2);
      `CHK("rext", 32'h80000040, operand2_o)
      `CHK("rextc", 1'b0, shift_carry_o)
      dec(cad_pkg::CLS_DATA, 32'hE0000020, 4'h0);
      `CHK("lsr32", 32'h0, operand2_o)
      dec(3'h6, 32'hE0000000, 4'h0);
      `CHK("noclass", 1'b0, reg_write_o | mem_access_o)
   endtask
   task automatic t_addr;
      dec(cad_pkg::CLS_PRIV, 32'hE1900123, 4'h0);
      `CHK("pre", 32'h1123, address_o)
      `CHK("prewb", 1'b0, base_write_o)
      dec(cad_pkg::CLS_PRIV, 32'hE2000200, 4'h0);
      `CHK("post", 32'h1000, address_o)
      `CHK("postup", 32'h800, base_update_o)
      `CHK("postwb", 1'b1, base_write_o)
      `CHK("mem", 1'b1, mem_access_o)
      dec(cad_pkg::CLS_PRIV, 32'hE38000C0, 4'h0);
      `CHK("asr", 32'h1040, address_o)
      dec(cad_pkg::CLS_PRIV, 32'hE3800060, 4'h2);
      `CHK("srext", 32'h80001040, address_o)
      dec(cad_pkg::CLS_COPROC, 32'hE1200010, 4'h0);
      `CHK("cpa", 32'hFC0, address_o)
      `CHK("cpwb", 1'b1, base_write_o)
      dec(cad_pkg::CLS_COPROC, 32'hE0800010, 4'h0);
      `CHK("cpost", 32'h1040, base_update_o)
   endtask
   task automatic t_multi;
      logic [1:0] m [4] = '{2'h1, 2'h3, 2'h0, 2'h2};
      for (int s = 0; s < 8; s++) begin
         dec(3'h2 + 3'(s / 4), 32'hE0200000 | (s % 4) << 23, 4'h0);
         `CHK("seq", m[s % 4], multi_seq_o)
      end
   endtask
   task automatic t_psr;
      for (int k = 0; k < 16; k++) begin
         dec(cad_pkg::CLS_PSRW, 32'hE0000000 | k << 16, 4'h0);
         `CHK("psr", k[3:0], psr_field_we_o)
      end
      dec(cad_pkg::CLS_PSRW, 32'h000F0000, 4'h0);
      `CHK("psrno", 4'h0, psr_field_we_o)
   endtask
   task automatic t_bus;
      wb(1'b0, cad_pkg::REG_CTRL, 32'h0);
      `CHK("ctrl", 32'h1, q)
      wb(1'b0, 8'h40, 32'h0);
      `CHK("unmap", 32'h0, q)
      wb(1'b1, cad_pkg::REG_CTRL, 32'h0);
      dec(cad_pkg::CLS_PRIV, 32'hE1900123, 4'h0);
      `CHK("offp", 1'b0, cond_pass_o)
      `CHK("offm", 1'b0, mem_access_o)
      wb(1'b0, cad_pkg::REG_STATUS, 32'h0);
      `CHK("stat", 32'h0, q)
      wb(1'b1, cad_pkg::REG_CTRL, 32'h1);
      dec(cad_pkg::CLS_PRIV, 32'hE1900123, 4'h0);
      `CHK("onm", 1'b1, mem_access_o)
      wb(1'b0, cad_pkg::REG_EXEC, 32'h0);
      `CHK("exec", 32'h1, q)
      wb(1'b0, cad_pkg::REG_SKIP, 32'h0);
      `CHK("skip", 32'h1, q)
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      t_bus();
      t_cond();
      t_op2();
      t_addr();
      t_multi();
      t_psr();
      conclude();
   end
endmodule // tb
`default_nettype wire
